//--- verilog/tdm_switch_pkg.sv
// Shared constants, types and helpers of the time-slot switch.
`default_nettype none
package tdm_switch_pkg;
    localparam int unsigned BUS_ADDR_W = 18;
    localparam int unsigned BUS_DATA_W = 32;
    localparam int unsigned BYTE_OFS_W = 2;
    localparam int unsigned STREAM_W   = 6;
    localparam int unsigned SLOT_W     = 8;
    localparam int unsigned LOC_W      = STREAM_W + SLOT_W;
    localparam int unsigned LOC_COUNT  = 1 << LOC_W;
    localparam int unsigned CM_W       = 16;
    localparam int unsigned SAMPLE_W   = 8;
    localparam int unsigned TX_W       = LOC_W + 1 + SAMPLE_W;
    localparam int unsigned REGION_HI  = 17;
    localparam int unsigned REGION_LO  = 16;
    localparam int unsigned MODE_HI    = 15;
    localparam int unsigned MODE_LO    = 14;
    localparam int unsigned SRC_HI     = 13;
    localparam logic [1:0]  REGION_CM  = 2'h2;
    localparam logic [1:0]  REGION_DM  = 2'h0;
    localparam logic [CM_W-1:0]     CM_CLEAR_WORD = 16'hC000;
    localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO   = 8'h00;

    typedef enum logic [1:0] {
        MODE_VARIABLE  = 2'h0,
        MODE_CONSTANT  = 2'h1,
        MODE_PROCESSOR = 2'h2,
        MODE_HIGH_Z    = 2'h3
    } switch_mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'h1,
        BUS_ANSWER = 2'h2
    } bus_state_t;

    function automatic logic [LOC_W-1:0] loc_of(input logic [BUS_ADDR_W-1:0] addr);
        loc_of = addr[LOC_W+BYTE_OFS_W-1:BYTE_OFS_W];
    endfunction : loc_of

    function automatic logic [CM_W-1:0] merge_lanes(input logic [CM_W-1:0] old_word,
                                                    input logic [CM_W-1:0] new_word,
                                                    input logic [1:0]      lanes);
        merge_lanes = {lanes[1] ? new_word[15:8] : old_word[15:8],
                       lanes[0] ? new_word[7:0]  : old_word[7:0]};
    endfunction : merge_lanes
endpackage : tdm_switch_pkg
`default_nettype wire

//--- verilog/skid_if.sv
// Valid/ready carrier for transmit words between the switch and its buffer.
`default_nettype none
interface skid_if import tdm_switch_pkg::*; ();
    logic            valid;
    logic            ready;
    logic [TX_W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : skid_if
`default_nettype wire

//--- verilog/tx_skid_buffer.sv
// Two-entry buffer in the transmit path; a stalled receiver loses no word.
`default_nettype none
module tx_skid_buffer
    import tdm_switch_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Upstream and downstream sides.
    skid_if.sink      up,
    skid_if.source    down
);
    logic            spare_valid;
    logic [TX_W-1:0] spare_data;
    logic            take_up;
    logic            drain_ok;

    // Ready depends only on a flop, so no combinational path runs back to the source.
    assign up.ready = !spare_valid;
    assign take_up  = up.valid && up.ready;
    assign drain_ok = down.ready || !down.valid;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            down.valid  <= 1'b0;
            down.data   <= '0;
            spare_valid <= 1'b0;
            spare_data  <= '0;
        end else if (drain_ok) begin
            if (spare_valid) begin
                down.valid  <= 1'b1;
                down.data   <= spare_data;
                spare_valid <= 1'b0;
            end else begin
                down.valid <= up.valid;
                down.data  <= up.data;
            end
        end else if (take_up) begin
            spare_valid <= 1'b1;
            spare_data  <= up.data;
        end
    end
endmodule : tx_skid_buffer
`default_nettype wire

//--- verilog/tdm_switch.sv
// Data and connection memories of a TDM time-slot switch with an Avalon-MM slave.
//
// Overview of operation
// - Every received slot of every stream is stored in the data memory.
// - Software may read the data memory; its writes there never change it.
// - Software reads and writes every connection memory location.
// - Processor mode sends the location's own low byte on that output slot.
// - Address bits 15:14 equal to 10 select the connection memory.
// - Address bits 13:8 pick output stream, bits 7:0 the output slot.
// - Connection memory has 16-bit address and word; address is destination.
// - The stored word names the input slot that feeds that output slot.
// - Word bits 15:14 give mode: variable, constant, processor, high impedance.
// - Word bits 13:8 give source stream, bits 7:0 source slot.
// - One write of source word to destination address makes the connection.
// - Any input slot may feed any output slot, without blocking.
`default_nettype none
module tdm_switch
    import tdm_switch_pkg::*;
#(
    parameter int unsigned CLEAR_LOCATIONS = LOC_COUNT
) (
    // Clock and reset.
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Avalon-MM slave.
    input  wire logic [BUS_ADDR_W-1:0] avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [BUS_DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [BUS_DATA_W-1:0] avs_readdata_o,
    output logic                       avs_waitrequest_o,
    // Receive side.
    input  wire logic                  frame_start_i,
    input  wire logic                  rx_valid_i,
    input  wire logic [STREAM_W-1:0]   rx_stream_i,
    input  wire logic [SLOT_W-1:0]     rx_slot_i,
    input  wire logic [SAMPLE_W-1:0]   rx_sample_i,
    // Transmit side.
    output logic                       tx_valid_o,
    input  wire logic                  tx_ready_i,
    output logic      [STREAM_W-1:0]   tx_stream_o,
    output logic      [SLOT_W-1:0]     tx_slot_o,
    output logic                       tx_drive_o,
    output logic      [SAMPLE_W-1:0]   tx_sample_o
);
    logic [CM_W-1:0]     conn_mem [LOC_COUNT];
    logic [SAMPLE_W-1:0] data_mem [2*LOC_COUNT];

    bus_state_t          state;
    bus_state_t          next_state;
    logic                rx_bank;
    logic                clearing;
    logic [LOC_W-1:0]    clr_loc;
    logic [LOC_W-1:0]    scan_loc;

    logic [1:0]          bus_region;
    logic [LOC_W-1:0]    bus_loc;
    logic                sel_cm;
    logic                sel_dm;
    logic                bus_req;
    logic                bus_take;
    logic                bus_write_done;
    logic [CM_W-1:0]     cm_bus_word;
    logic [CM_W-1:0]     cm_merged;
    logic [LOC_W:0]      dm_bus_addr;
    logic [BUS_DATA_W-1:0] read_value;

    logic [LOC_W-1:0]    rx_loc;
    logic [CM_W-1:0]     cur_conn;
    switch_mode_t        cur_mode;
    logic [LOC_W-1:0]    src_loc;
    logic [SAMPLE_W-1:0] var_sample;
    logic [SAMPLE_W-1:0] const_sample;
    logic [SAMPLE_W-1:0] push_sample;
    logic                push_drive;
    logic                push_fire;

    skid_if up_link ();
    skid_if down_link ();

    // Bus decode; the low two byte-address bits are ignored, and byteenable picks the lanes.
    assign bus_region     = avs_address_i[REGION_HI:REGION_LO];
    assign bus_loc        = loc_of(avs_address_i);
    assign sel_cm         = (bus_region == REGION_CM);
    assign sel_dm         = (bus_region == REGION_DM);
    assign bus_req        = avs_read_i || avs_write_i;
    assign bus_take       = bus_req && !clearing && (state == BUS_IDLE);
    assign bus_write_done = avs_write_i && (state == BUS_ANSWER);
    assign cm_bus_word    = conn_mem[bus_loc];
    assign cm_merged      = merge_lanes(cm_bus_word, avs_writedata_i[CM_W-1:0],
                                        avs_byteenable_i[1:0]);
    assign dm_bus_addr    = {rx_bank, bus_loc};
    // Unmapped regions read as zero, so a stray read still returns a defined word.
    assign read_value     = sel_cm ? {{(BUS_DATA_W-CM_W){1'b0}}, cm_bus_word} :
                            sel_dm ? {{(BUS_DATA_W-SAMPLE_W){1'b0}}, data_mem[dm_bus_addr]} :
                            '0;

    always_comb begin
        case (state)
            BUS_IDLE:   next_state = bus_take ? BUS_ANSWER : BUS_IDLE;
            BUS_ANSWER: next_state = BUS_IDLE;
            default:    next_state = BUS_IDLE;
        endcase
    end

    // Read data is latched on the same edge that drops waitrequest, so the answer stands when waitrequest drops.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state             <= BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= '0;
        end else begin
            state             <= next_state;
            avs_waitrequest_o <= !bus_take;
            if (bus_take) begin
                avs_readdata_o <= read_value;
            end
        end
    end

    // After reset the locations below CLEAR_LOCATIONS (all by default) are swept to high impedance, so their outputs carry no junk.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clearing <= 1'b1;
            clr_loc  <= '0;
        end else if (clearing) begin
            clr_loc  <= clr_loc + 1'b1;
            clearing <= (clr_loc != LOC_W'(CLEAR_LOCATIONS - 1));
        end
    end

    // Connection memory: a single write sets up a connection; data memory is never written here.
    always_ff @(posedge clk_i) begin
        if (clearing) begin
            conn_mem[clr_loc] <= CM_CLEAR_WORD;
        end else if (bus_write_done && sel_cm) begin
            conn_mem[bus_loc] <= cm_merged;
        end
    end

    // Two banks: the one being filled and the one filled during the previous frame.
    assign rx_loc = {rx_stream_i, rx_slot_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_bank <= 1'b0;
        end else if (frame_start_i) begin
            rx_bank <= !rx_bank;
        end
    end

    always_ff @(posedge clk_i) begin
        if (clearing) begin
            data_mem[{1'b0, clr_loc}] <= SAMPLE_ZERO;
            data_mem[{1'b1, clr_loc}] <= SAMPLE_ZERO;
        end
        if (rx_valid_i) begin
            data_mem[{rx_bank, rx_loc}] <= rx_sample_i;
        end
    end

    // Transmit scan: each output slot in turn reads its connection word live.
    assign cur_conn     = conn_mem[scan_loc];
    assign cur_mode     = switch_mode_t'(cur_conn[MODE_HI:MODE_LO]);
    assign src_loc      = cur_conn[SRC_HI:0];
    // Constant delay costs a frame of latency but gives every connection the same delay.
    assign var_sample   = data_mem[{rx_bank, src_loc}];
    assign const_sample = data_mem[{!rx_bank, src_loc}];
    assign push_sample  = (cur_mode == MODE_VARIABLE)  ? var_sample :
                          (cur_mode == MODE_CONSTANT)  ? const_sample :
                          (cur_mode == MODE_PROCESSOR) ? cur_conn[SAMPLE_W-1:0] :
                          SAMPLE_ZERO;
    assign push_drive   = (cur_mode != MODE_HIGH_Z);
    assign push_fire    = up_link.valid && up_link.ready;

    assign up_link.valid = !clearing;
    assign up_link.data  = {scan_loc, push_drive, push_sample};

    // The scan stalls with the buffer, so a full sweep is one frame of output.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scan_loc <= '0;
        end else if (push_fire) begin
            scan_loc <= scan_loc + 1'b1;
        end
    end

    tx_skid_buffer u_buffer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .up    (up_link),
        .down  (down_link)
    );

    assign down_link.ready = tx_ready_i;
    assign tx_valid_o      = down_link.valid;
    assign tx_stream_o     = down_link.data[TX_W-1:TX_W-STREAM_W];
    assign tx_slot_o       = down_link.data[TX_W-STREAM_W-1:SAMPLE_W+1];
    assign tx_drive_o      = down_link.data[SAMPLE_W];
    assign tx_sample_o     = down_link.data[SAMPLE_W-1:0];

    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic [SAMPLE_W-1:0] dm_probe;
    logic                rx_hits_probe;
    assign dm_probe      = data_mem[dm_bus_addr];
    assign rx_hits_probe = rx_valid_i && (rx_loc == bus_loc);

    // Destination the next transmit word must carry; counted apart from the scan.
    logic [LOC_W-1:0]    expect_tx_loc;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            expect_tx_loc <= '0;
        end else if (tx_valid_o && tx_ready_i) begin
            expect_tx_loc <= expect_tx_loc + 1'b1;
        end
    end

    rx_store_a: assert property (rx_valid_i |=>
        data_mem[{$past(rx_bank), $past(rx_loc)}] == $past(rx_sample_i))
        else $error("Received sample not stored.");

    dm_write_held_a: assert property (
        bus_write_done && sel_dm && !rx_hits_probe && !frame_start_i
        |=> data_mem[$past(dm_bus_addr)] == $past(dm_probe))
        else $error("Data memory changed by a bus write.");

    cm_write_a: assert property (bus_write_done && sel_cm
        && avs_byteenable_i[1:0] == 2'h3
        |=> conn_mem[$past(bus_loc)] == $past(avs_writedata_i[CM_W-1:0]))
        else $error("Connection word not stored.");

    cm_read_a: assert property (bus_take && avs_read_i && sel_cm
        |=> !avs_waitrequest_o && avs_readdata_o[CM_W-1:0] == conn_mem[$past(bus_loc)])
        else $error("Connection word read back wrong.");

    region_decode_a: assert property (bus_take && avs_write_i
        && avs_address_i[REGION_HI:REGION_LO] != REGION_CM
        |=> ##1 conn_mem[$past(bus_loc, 2)] == $past(cm_bus_word, 2))
        else $error("Write outside the region changed a connection.");

    proc_mode_a: assert property (push_fire && cur_mode == MODE_PROCESSOR
        |-> push_drive && push_sample == cur_conn[SAMPLE_W-1:0])
        else $error("Processor byte not sent.");

    high_z_a: assert property (push_fire && cur_mode == MODE_HIGH_Z
        |-> !push_drive)
        else $error("High impedance slot driven.");

    source_pick_a: assert property (push_fire && cur_mode == MODE_CONSTANT
        |-> push_sample == data_mem[{!rx_bank, cur_conn[SRC_HI:0]}])
        else $error("Wrong source slot switched.");

    scan_step_a: assert property (push_fire |=> scan_loc == $past(scan_loc) + 1'b1)
        else $error("Scan did not advance.");

    bus_answer_a: assert property (bus_take
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("Bus answer not one cycle long.");

    cm_lane_a: assert property (bus_write_done && sel_cm
        && avs_byteenable_i[1:0] == 2'h1
        |=> conn_mem[$past(bus_loc)][CM_W-1:SAMPLE_W] == $past(cm_bus_word[CM_W-1:SAMPLE_W]))
        else $error("Disabled byte lane changed.");

    dm_read_a: assert property (bus_take && avs_read_i && sel_dm
        |=> avs_readdata_o == {{(BUS_DATA_W-SAMPLE_W){1'b0}}, $past(dm_probe)})
        else $error("Data memory read back wrong.");

    unmapped_read_a: assert property (bus_take && avs_read_i && !sel_cm && !sel_dm
        |=> avs_readdata_o == '0)
        else $error("Unmapped read not zero.");

    read_hold_a: assert property (!bus_take |=> $stable(avs_readdata_o))
        else $error("Read data moved without a request.");

    sweep_wait_a: assert property (clearing |=> avs_waitrequest_o)
        else $error("Bus answered during the reset sweep.");

    // A short reset sweep leaves data fields unknown, so only the destination is held here.
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i
        |=> tx_valid_o && $stable({tx_stream_o, tx_slot_o}))
        else $error("Stalled transmit word lost.");

    tx_order_a: assert property (tx_valid_o
        |-> {tx_stream_o, tx_slot_o} == expect_tx_loc)
        else $error("Output slot out of order.");

    tx_quiet_a: assert property (tx_valid_o && !tx_drive_o
        |-> tx_sample_o == SAMPLE_ZERO)
        else $error("Undriven slot carries data.");

    cm_write_c:  cover property (bus_write_done && sel_cm);
    tx_stall_c:  cover property (tx_valid_o && !tx_ready_i [*2]);
    proc_push_c: cover property (push_fire && cur_mode == MODE_PROCESSOR);
    hi_z_push_c: cover property (push_fire && cur_mode == MODE_HIGH_Z);
    const_push_c: cover property (push_fire && cur_mode == MODE_CONSTANT);
endmodule : tdm_switch
`default_nettype wire

//--- tb/tx_sink_model.sv
// Transmit-side receiver model that stalls at random and flags each accepted word.
`default_nettype none
module tx_sink_model (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Transmit handshake.
    input  wire logic tx_valid_i,
    output logic      tx_ready_o,
    output logic      accept_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lfsr;
    // Ready drops about one cycle in four, so the two-entry buffer fills and drains.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lfsr       <= 16'hACE1;
            tx_ready_o <= 1'b0;
        end else begin
            lfsr       <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? 16'hB400 : 16'h0000);
            tx_ready_o <= lfsr[0] | lfsr[1];
        end
    end
    assign accept_o = tx_valid_i & tx_ready_o;
endmodule : tx_sink_model
`default_nettype wire

//--- tb/test_tdm_timeslot_connection_memory.sv
// Self-checking bench of the time-slot switch: bus accesses, receive stores, transmit words.
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_tdm_timeslot_connection_memory import tdm_switch_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [LOC_W-1:0]  loc;
        logic [SAMPLE_W:0] word;
    } tx_note_t;
    logic                  clk       = 1'b0;
    logic                  rst       = 1'b1;
    logic [BUS_ADDR_W-1:0] bus_addr  = '0;
    logic                  bus_rd    = 1'b0;
    logic                  bus_wr    = 1'b0;
    logic [BUS_DATA_W-1:0] bus_wdata = '0;
    logic [3:0]            bus_be    = 4'h0;
    logic [BUS_DATA_W-1:0] bus_rdata;
    logic                  bus_wait;
    logic                  frame     = 1'b0;
    logic                  rx_valid  = 1'b0;
    logic [STREAM_W-1:0]   rx_stream = '0;
    logic [SLOT_W-1:0]     rx_slot   = '0;
    logic [SAMPLE_W-1:0]   rx_sample = '0;
    logic                  tx_valid, tx_ready, tx_accept, tx_drive;
    logic [STREAM_W-1:0]   tx_stream;
    logic [SLOT_W-1:0]     tx_slot;
    logic [SAMPLE_W-1:0]   tx_sample, smp, pbyte;
    logic [31:0]           rnd       = 32'h5BA8;
    logic [31:0]           read_head;
    logic [BUS_DATA_W-1:0] read_notes[$];
    tx_note_t              tx_notes[$];
    tx_note_t              tx_head;
    logic [LOC_W-1:0]      tx_expect_loc = '0;
    int                    err_total = 0;
    int                    n_compared = 0;
    int                    wrap_count = 0;

    always #4 clk = ~clk;

    tdm_switch #(.CLEAR_LOCATIONS(LOC_COUNT)) dut (
        .clk_i(clk), .rst_i(rst), .avs_address_i(bus_addr), .avs_read_i(bus_rd),
        .avs_write_i(bus_wr), .avs_writedata_i(bus_wdata), .avs_byteenable_i(bus_be),
        .avs_readdata_o(bus_rdata), .avs_waitrequest_o(bus_wait), .frame_start_i(frame),
        .rx_valid_i(rx_valid), .rx_stream_i(rx_stream), .rx_slot_i(rx_slot),
        .rx_sample_i(rx_sample), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .tx_stream_o(tx_stream), .tx_slot_o(tx_slot), .tx_drive_o(tx_drive),
        .tx_sample_o(tx_sample));
    tx_sink_model sink (.clk_i(clk), .rst_i(rst), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready), .accept_o(tx_accept));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    task automatic test_done;
        $display("Compared %0d values, %0d wrong", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    // The request is held until waitrequest is sampled low; no latency is assumed.
    task automatic bus_access(input logic wr, input logic [1:0] region,
                              input logic [LOC_W-1:0] loc, input logic [15:0] data,
                              input logic [3:0] be);
        @(posedge clk);
        bus_rd    <= ~wr;
        bus_wr    <= wr;
        bus_addr  <= {region, loc, 2'h0};
        bus_wdata <= {16'h0000, data};
        bus_be    <= be;
        @(posedge clk);
        while (bus_wait !== 1'b0) @(posedge clk);
        bus_rd <= 1'b0;
        bus_wr <= 1'b0;
    endtask : bus_access

    task automatic rd(input logic [1:0] region, input logic [LOC_W-1:0] loc,
                      input logic [31:0] exp);
        read_notes.push_back(exp);
        bus_access(1'b0, region, loc, 16'h0000, 4'hF);
    endtask : rd

    task automatic rx_store(input logic [STREAM_W-1:0] s, input logic [SLOT_W-1:0] t,
                            input logic [SAMPLE_W-1:0] v);
        @(posedge clk);
        rx_valid  <= 1'b1;
        rx_stream <= s;
        rx_slot   <= t;
        rx_sample <= v;
        @(posedge clk);
        rx_valid  <= 1'b0;
        rx_sample <= ~v;
    endtask : rx_store

    always @(posedge clk) begin
        if (bus_rd === 1'b1 && bus_wait === 1'b0) begin
            read_head = read_notes.pop_front();
            `CHK(bus_rdata, read_head)
        end
        if (rst === 1'b0 && tx_accept === 1'b1) begin
            `CHK({tx_stream, tx_slot}, tx_expect_loc)
            tx_expect_loc = tx_expect_loc + 1'b1;
            if ({tx_stream, tx_slot} === '0) wrap_count++;
            if (tx_notes.size() > 0 && {tx_stream, tx_slot} === tx_notes[0].loc) begin
                tx_head = tx_notes.pop_front();
                `CHK({tx_drive, tx_sample}, tx_head.word)
            end
        end
    end

    initial begin
        int n;
        repeat (4) @(posedge clk);
        `CHK(bus_wait, 1'b1)
        rst <= 1'b0;
        rnd = lfsr_next(rnd);
        smp = rnd[7:0];
        rnd = lfsr_next(rnd);
        pbyte = rnd[15:8];
        rd(REGION_CM, 14'h0005, 32'h0000C000);
        bus_access(1'b1, REGION_CM, 14'h0D09, 16'h4400, 4'h3);
        rd(REGION_CM, 14'h0D09, 32'h00004400);
        bus_access(1'b1, REGION_CM, 14'h0D0A, 16'h0400, 4'h3);
        bus_access(1'b1, REGION_CM, 14'h0D0B, 16'h80FF, 4'h3);
        bus_access(1'b1, REGION_CM, 14'h0D0B, {8'h55, pbyte}, 4'h1);
        rd(REGION_CM, 14'h0D0B, {16'h0000, 8'h80, pbyte});
        bus_access(1'b1, REGION_CM, 14'h0005, 16'h8011, 4'h3);
        bus_access(1'b1, REGION_CM, 14'h0005, CM_CLEAR_WORD, 4'h3);
        // The same byte goes into both banks so both delay modes give one answer.
        rx_store(6'h04, 8'h00, smp);
        @(posedge clk);
        frame <= 1'b1;
        @(posedge clk);
        frame <= 1'b0;
        rx_store(6'h04, 8'h00, smp);
        rd(REGION_DM, 14'h0400, {24'h000000, smp});
        bus_access(1'b1, REGION_DM, 14'h0400, {8'h00, ~smp}, 4'h3);
        rd(REGION_DM, 14'h0400, {24'h000000, smp});
        bus_access(1'b1, 2'h1, 14'h0D09, 16'h1234, 4'h3);
        rd(2'h1, 14'h0D09, 32'h00000000);
        rd(2'h3, 14'h0D09, 32'h00000000);
        rd(REGION_CM, 14'h0D09, 32'h00004400);
        // Expectations start at a wrap, so every write has had a full sweep to land.
        n = wrap_count;
        while (wrap_count == n) @(posedge clk);
        tx_notes.push_back({14'h0005, 1'b0, 8'h00});
        tx_notes.push_back({14'h0D09, 1'b1, smp});
        tx_notes.push_back({14'h0D0A, 1'b1, smp});
        tx_notes.push_back({14'h0D0B, 1'b1, pbyte});
        while (tx_notes.size() > 0) @(posedge clk);
        test_done();
    end

    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        test_done();
    end
endmodule : test_tdm_timeslot_connection_memory
`default_nettype wire
